// File: include/bkr_pkg.sv
// Operation
// - sources latch on either edge, bit map
// - latched flags clear after being read
// - live register mirrors present source state
// - thermal live bits follow their thresholds
// - mask zero enables, one suppresses; spare one
// - mask resets to all ones
// - preset holds code and gate; pin chooses
// - monitor bit switches power-ok function
// - timeout reset delay 0/8/32/64 ms
// - pin debounce window by timing code
// - ramp step period by timing code
// - enable delay 0 to 14 ms
// - select gating off forces high preset
// - both pins low: low-iq or sleep
// - ramp mode auto or forced pulse
// - reserved addresses read zero, ignore writes
// - variant reset defaults for both presets only
// - unmasked latched flag pulls interrupt low
// - reading latched flags releases interrupt
// - command picks pulse mode per select
`default_nettype none
package bkr_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CNT_W = 24;
    // register offsets
    localparam logic [7:0] OFF_LATCHED = 8'h00;
    localparam logic [7:0] OFF_LIVE = 8'h01;
    localparam logic [7:0] OFF_MASK = 8'h02;
    localparam logic [7:0] OFF_PRODUCT = 8'h03;
    localparam logic [7:0] OFF_REVISION = 8'h04;
    localparam logic [7:0] OFF_FEATURE = 8'h05;
    localparam logic [7:0] OFF_PRESET_HIGH = 8'h10;
    localparam logic [7:0] OFF_PRESET_LOW = 8'h11;
    localparam logic [7:0] OFF_POK_CTRL = 8'h12;
    localparam logic [7:0] OFF_TIMING = 8'h13;
    localparam logic [7:0] OFF_COMMAND = 8'h14;
    localparam logic [7:0] OFF_LIMITS = 8'h16;
    // source bit map, spare at bit 4
    localparam logic [7:0] SRC_BITS = 8'hEF;
    localparam logic [7:0] MASK_SPARE_ONE = 8'h10;
    localparam int unsigned BIT_POWER_OK = 0;
    // field positions
    localparam int unsigned PRESET_GATE = 7;
    localparam int unsigned POK_MONITOR_ON = 0;
    localparam int unsigned POK_DURING_RAMP = 1;
    localparam int unsigned POK_TOR_LSB = 2;
    localparam int unsigned POK_DRAIN_ON = 4;
    localparam int unsigned TIM_DBN_LSB = 0;
    localparam int unsigned TIM_RAMP_LSB = 3;
    localparam int unsigned TIM_DELAY_LSB = 5;
    localparam int unsigned CMD_SEL_GATING = 0;
    localparam int unsigned CMD_SLEEP = 4;
    localparam int unsigned CMD_RAMP_MODE = 5;
    localparam int unsigned CMD_PWM_HIGH = 6;
    localparam int unsigned CMD_PWM_LOW = 7;
    // writable bits per register
    localparam logic [7:0] WR_POK_CTRL = 8'h1F;
    localparam logic [7:0] WR_TIMING = 8'hFB;
    localparam logic [7:0] WR_COMMAND = 8'hF3;
    // reset values
    localparam logic [7:0] RST_LATCHED = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hFF;
    localparam logic [7:0] RST_PRESET_STD = 8'hC0;
    localparam logic [7:0] RST_PRESET_HIGH_ALT = 8'hA0;
    localparam logic [7:0] RST_PRESET_LOW_ALT = 8'h88;
    localparam logic [7:0] RST_POK_CTRL = 8'h10;
    localparam logic [7:0] RST_TIMING = 8'h09;
    localparam logic [7:0] RST_COMMAND = 8'hC3;
    localparam logic [7:0] RST_LIMITS = 8'hE3;
    // times and cycle counts
    localparam int unsigned DBN_UNIT_US = 1;
    localparam int unsigned DBN_UNIT_CYC = DBN_UNIT_US * CLK_MHZ;
    localparam int unsigned DELAY_STEP_MS = 2;
    localparam int unsigned TOR_MS_1 = 8;
    localparam int unsigned TOR_MS_2 = 32;
    localparam int unsigned TOR_MS_3 = 64;
    localparam int unsigned CYC_PER_MS = 1000 * CLK_MHZ;
    localparam int unsigned RAMP_NS_0 = 333;
    localparam int unsigned RAMP_NS_1 = 666;
    localparam int unsigned RAMP_NS_2 = 1333;
    localparam int unsigned RAMP_NS_3 = 2666;
    localparam int unsigned RAMP_CYC_0 = RAMP_NS_0 * CLK_MHZ / 1000;
    localparam int unsigned RAMP_CYC_1 = RAMP_NS_1 * CLK_MHZ / 1000;
    localparam int unsigned RAMP_CYC_2 = RAMP_NS_2 * CLK_MHZ / 1000;
    localparam int unsigned RAMP_CYC_3 = RAMP_NS_3 * CLK_MHZ / 1000;
    // enable sequencer
    typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_ON} bkr_seq_e;
    // register access request from the link side
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bkr_req_s;
    // controls toward the regulation loop
    typedef struct packed {
        logic on;
        logic [6:0] vout_code;
        logic ramping;
        logic forced_pwm;
        logic sleep;
        logic low_iq;
        logic drain_on;
    } bkr_ctrl_s;
endpackage
`default_nettype wire

// File: rtl/bkr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module bkr_regs #(
    parameter int unsigned MS_CYC = bkr_pkg::CYC_PER_MS,
    parameter bit VARIANT_ALT = 1'b0,
    // identification values are arbitrary
    parameter logic [7:0] PRODUCT_CODE = 8'h5A,
    parameter logic [7:0] REVISION_CODE = 8'h3C,
    parameter logic [3:0] FEATURE_CODE = 4'hA
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link side register access
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic link_req_valid,
    input wire bkr_pkg::bkr_req_s link_req,
    output logic link_busy,
    output logic link_done,
    output logic [7:0] link_rdata,
    // raw source conditions and pins
    input wire logic [7:0] cond_raw,
    input wire logic enable_pin,
    input wire logic setting_select_pin,
    // open-drain outputs
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_n,
    output logic power_ok_o,
    output logic power_ok_oe_n,
    // regulator controls
    output bkr_pkg::bkr_ctrl_s ctrl_o
);
    import bkr_pkg::*;

    typedef struct packed {
        logic req_t;
        bkr_req_s hold;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic [7:0] rdata;
        logic done;
    } bkr_link_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_t;
        logic [7:0] rdata;
        logic [7:0] cond_s1;
        logic [7:0] cond_s2;
        logic [7:0] cond_prev;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_db;
        logic [1:0][9:0] dbn_cnt;
        logic [7:0] latched;
        logic [7:0] mask;
        logic [7:0] preset_high;
        logic [7:0] preset_low;
        logic [7:0] pok_ctrl;
        logic [7:0] timing;
        logic [7:0] command;
        logic [7:0] limits;
        bkr_seq_e seq;
        logic [CNT_W-1:0] dly_cnt;
        logic [CNT_W-1:0] tor_cnt;
        logic pok_good;
        logic [11:0] step_cnt;
        logic int_drv;
        bkr_ctrl_s ctrl;
    } bkr_core_s;

    localparam logic [7:0] RST_PH = VARIANT_ALT ? RST_PRESET_HIGH_ALT : RST_PRESET_STD;
    localparam logic [7:0] RST_PL = VARIANT_ALT ? RST_PRESET_LOW_ALT : RST_PRESET_STD;

    bkr_link_s lk_ff;
    bkr_link_s nxt_lk;
    bkr_core_s st_ff;
    bkr_core_s nxt_st;
    logic access;
    logic [7:0] edges;
    logic sel_eff;
    logic en_req;
    logic [7:0] preset;
    logic ramping;
    logic good_raw;

    // timeout delay per code
    function automatic logic [CNT_W-1:0] tor_cycles(input logic [1:0] code);
        case (code)
            2'b01: tor_cycles = CNT_W'(TOR_MS_1 * MS_CYC);
            2'b10: tor_cycles = CNT_W'(TOR_MS_2 * MS_CYC);
            2'b11: tor_cycles = CNT_W'(TOR_MS_3 * MS_CYC);
            default: tor_cycles = '0;
        endcase
    endfunction

    // ramp step period per code
    function automatic logic [11:0] ramp_cycles(input logic [1:0] code);
        case (code)
            2'b01: ramp_cycles = 12'(RAMP_CYC_1);
            2'b10: ramp_cycles = 12'(RAMP_CYC_2);
            2'b11: ramp_cycles = 12'(RAMP_CYC_3);
            default: ramp_cycles = 12'(RAMP_CYC_0);
        endcase
    endfunction

    // read decode, reserved reads zero
    function automatic logic [7:0] read_value(input bkr_core_s s, input logic [7:0] a);
        case (a)
            OFF_LATCHED: read_value = s.latched;
            OFF_LIVE: read_value = s.cond_s2 & SRC_BITS;
            OFF_MASK: read_value = s.mask;
            OFF_PRODUCT: read_value = PRODUCT_CODE;
            OFF_REVISION: read_value = REVISION_CODE;
            OFF_FEATURE: read_value = {4'h0, FEATURE_CODE};
            OFF_PRESET_HIGH: read_value = s.preset_high;
            OFF_PRESET_LOW: read_value = s.preset_low;
            OFF_POK_CTRL: read_value = s.pok_ctrl;
            OFF_TIMING: read_value = s.timing;
            OFF_COMMAND: read_value = s.command;
            OFF_LIMITS: read_value = s.limits;
            default: read_value = 8'h00;
        endcase
    endfunction

    // link domain: take request, toggle, wait for answer
    always_comb
    begin
        nxt_lk = lk_ff;
        nxt_lk.done = 1'b0;
        nxt_lk.ack_s1 = st_ff.ack_t;
        nxt_lk.ack_s2 = lk_ff.ack_s1;
        if (lk_ff.busy && (lk_ff.ack_s2 != lk_ff.ack_seen))
        begin
            nxt_lk.ack_seen = lk_ff.ack_s2;
            nxt_lk.rdata = st_ff.rdata; // stable since the toggle
            nxt_lk.done = 1'b1;
            nxt_lk.busy = 1'b0;
        end
        else if (link_req_valid && !lk_ff.busy)
        begin
            nxt_lk.hold = link_req;
            nxt_lk.req_t = ~lk_ff.req_t;
            nxt_lk.busy = 1'b1;
        end
    end

    // link domain register
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
            lk_ff <= '0;
        else
            lk_ff <= nxt_lk;
    end

    assign link_busy = lk_ff.busy;
    assign link_done = lk_ff.done;
    assign link_rdata = lk_ff.rdata;

    // core helpers
    always_comb
    begin
        access = st_ff.req_s2 != st_ff.req_seen;
        edges = (st_ff.cond_s2 ^ st_ff.cond_prev) & SRC_BITS;
        sel_eff = st_ff.command[CMD_SEL_GATING] ? st_ff.pin_db[1] : 1'b1;
        preset = sel_eff ? st_ff.preset_high : st_ff.preset_low;
        en_req = preset[PRESET_GATE] ? st_ff.pin_db[0] : 1'b1;
        ramping = (st_ff.seq == SEQ_ON) && (st_ff.ctrl.vout_code != preset[6:0]);
        good_raw = st_ff.pok_ctrl[POK_MONITOR_ON] && (st_ff.seq == SEQ_ON)
            && st_ff.cond_s2[BIT_POWER_OK]
            && (!ramping || st_ff.pok_ctrl[POK_DURING_RAMP]);
    end

    // core next state
    always_comb
    begin
        logic [1:0] dcode;
        logic [9:0] need;
        dcode = st_ff.timing[TIM_DBN_LSB +: 2];
        need = 10'(32'(dcode) * DBN_UNIT_CYC);
        nxt_st = st_ff;
        nxt_st.req_s1 = lk_ff.req_t;
        nxt_st.req_s2 = st_ff.req_s1;
        nxt_st.cond_s1 = cond_raw;
        nxt_st.cond_s2 = st_ff.cond_s1;
        nxt_st.cond_prev = st_ff.cond_s2;
        nxt_st.pin_s1 = {setting_select_pin, enable_pin};
        nxt_st.pin_s2 = st_ff.pin_s1;
        for (int i = 0; i < 2; i++)
        begin
            if (dcode == 2'b00 || st_ff.pin_s2[i] == st_ff.pin_db[i])
            begin
                nxt_st.pin_db[i] = st_ff.pin_s2[i];
                nxt_st.dbn_cnt[i] = '0;
            end
            else if (st_ff.dbn_cnt[i] + 10'd1 >= need)
            begin
                nxt_st.pin_db[i] = st_ff.pin_s2[i];
                nxt_st.dbn_cnt[i] = '0;
            end
            else
                nxt_st.dbn_cnt[i] = st_ff.dbn_cnt[i] + 10'd1;
        end
        if (access && !lk_ff.hold.wr && lk_ff.hold.addr == OFF_LATCHED)
            nxt_st.latched = edges;
        else
            nxt_st.latched = st_ff.latched | edges;
        // register access
        if (access)
        begin
            nxt_st.req_seen = st_ff.req_s2;
            nxt_st.ack_t = ~st_ff.ack_t;
            nxt_st.rdata = read_value(st_ff, lk_ff.hold.addr);
            if (lk_ff.hold.wr)
            begin
                nxt_st.rdata = 8'h00;
                case (lk_ff.hold.addr)
                    OFF_MASK: nxt_st.mask = lk_ff.hold.wdata | MASK_SPARE_ONE;
                    OFF_PRESET_HIGH: nxt_st.preset_high = lk_ff.hold.wdata;
                    OFF_PRESET_LOW: nxt_st.preset_low = lk_ff.hold.wdata;
                    OFF_POK_CTRL: nxt_st.pok_ctrl = lk_ff.hold.wdata & WR_POK_CTRL;
                    OFF_TIMING: nxt_st.timing = lk_ff.hold.wdata & WR_TIMING;
                    OFF_COMMAND: nxt_st.command = lk_ff.hold.wdata & WR_COMMAND;
                    OFF_LIMITS: nxt_st.limits = lk_ff.hold.wdata;
                    default: nxt_st.limits = st_ff.limits;
                endcase
            end
        end
        case (st_ff.seq)
            SEQ_OFF:
            begin
                if (en_req)
                begin
                    nxt_st.seq = SEQ_DELAY;
                    nxt_st.dly_cnt = CNT_W'(32'(st_ff.timing[TIM_DELAY_LSB +: 3])
                        * DELAY_STEP_MS * MS_CYC);
                end
            end
            SEQ_DELAY:
            begin
                if (!en_req)
                    nxt_st.seq = SEQ_OFF;
                else if (st_ff.dly_cnt == '0)
                    nxt_st.seq = SEQ_ON;
                else
                    nxt_st.dly_cnt = st_ff.dly_cnt - CNT_W'(1);
            end
            SEQ_ON:
            begin
                if (!en_req)
                    nxt_st.seq = SEQ_OFF;
            end
            default: nxt_st.seq = SEQ_OFF;
        endcase
        nxt_st.step_cnt = '0;
        if (st_ff.seq != SEQ_ON)
            nxt_st.ctrl.vout_code = '0;
        else if (ramping)
        begin
            if (st_ff.step_cnt + 12'd1 >= ramp_cycles(st_ff.timing[TIM_RAMP_LSB +: 2]))
            begin
                if (st_ff.ctrl.vout_code < preset[6:0])
                    nxt_st.ctrl.vout_code = st_ff.ctrl.vout_code + 7'd1;
                else
                    nxt_st.ctrl.vout_code = st_ff.ctrl.vout_code - 7'd1;
            end
            else
                nxt_st.step_cnt = st_ff.step_cnt + 12'd1;
        end
        if (!good_raw)
        begin
            nxt_st.tor_cnt = '0;
            nxt_st.pok_good = 1'b0;
        end
        else if (st_ff.tor_cnt >= tor_cycles(st_ff.pok_ctrl[POK_TOR_LSB +: 2]))
            nxt_st.pok_good = 1'b1;
        else
            nxt_st.tor_cnt = st_ff.tor_cnt + CNT_W'(1);
        nxt_st.ctrl.on = st_ff.seq == SEQ_ON;
        nxt_st.ctrl.ramping = ramping;
        if (ramping)
            nxt_st.ctrl.forced_pwm = st_ff.command[CMD_RAMP_MODE];
        else
            nxt_st.ctrl.forced_pwm = sel_eff ? st_ff.command[CMD_PWM_HIGH]
                : st_ff.command[CMD_PWM_LOW];
        nxt_st.ctrl.sleep = (st_ff.pin_db == 2'b00) && st_ff.command[CMD_SLEEP];
        nxt_st.ctrl.low_iq = (st_ff.pin_db == 2'b00) && !st_ff.command[CMD_SLEEP];
        nxt_st.ctrl.drain_on = st_ff.pok_ctrl[POK_DRAIN_ON] && (st_ff.seq == SEQ_OFF);
        nxt_st.int_drv = |(nxt_st.latched & ~nxt_st.mask & SRC_BITS);
    end

    // core register, frozen while ce low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.seq <= SEQ_OFF;
            st_ff.latched <= RST_LATCHED;
            st_ff.mask <= RST_MASK;
            st_ff.preset_high <= RST_PH;
            st_ff.preset_low <= RST_PL;
            st_ff.pok_ctrl <= RST_POK_CTRL;
            st_ff.timing <= RST_TIMING;
            st_ff.command <= RST_COMMAND;
            st_ff.limits <= RST_LIMITS;
        end
        else if (ce)
            st_ff <= nxt_st;
    end

    // open-drain pins, low when enable low
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe_n = ~st_ff.int_drv;
    assign power_ok_o = 1'b0;
    assign power_ok_oe_n = st_ff.pok_good;
    assign ctrl_o = st_ff.ctrl;

    // checks in the core domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_EDGE_LATCH: assert property (
        (ce && st_ff.cond_s2[3] != st_ff.cond_prev[3]) |=> st_ff.latched[3])
        else $error("source edge not latched");
    AST_READ_CLEAR: assert property (
        (ce && access && !lk_ff.hold.wr && lk_ff.hold.addr == OFF_LATCHED && edges == 8'h00)
        |=> (st_ff.latched == 8'h00) && (st_ff.rdata == $past(st_ff.latched)))
        else $error("latched read did not return and clear");
    AST_LIVE_READ: assert property (
        (ce && access && !lk_ff.hold.wr && lk_ff.hold.addr == OFF_LIVE)
        |=> st_ff.rdata == ($past(st_ff.cond_s2) & SRC_BITS))
        else $error("live read mismatch");
    AST_MASK_SPARE: assert property (
        st_ff.mask[4] && !st_ff.latched[4])
        else $error("spare bit value wrong");
    AST_INT_PIN: assert property (
        interrupt_out_n_oe_n == !(|(st_ff.latched & ~st_ff.mask)))
        else $error("interrupt pin disagrees with flags");
    AST_RESERVED_READ: assert property (
        (ce && access && !lk_ff.hold.wr && lk_ff.hold.addr >= 8'h20) |=> st_ff.rdata == 8'h00)
        else $error("reserved read not zero");
    AST_TOR_ZERO: assert property (
        (ce && good_raw && st_ff.pok_ctrl[3:2] == 2'b00) |=> st_ff.pok_good)
        else $error("power ok late with zero timeout");
    AST_SLEEP_SEL: assert property (
        (ce && st_ff.pin_db == 2'b00)
        |=> (st_ff.ctrl.sleep == $past(st_ff.command[4])) && (st_ff.ctrl.low_iq != st_ff.ctrl.sleep))
        else $error("sleep choice wrong");
    AST_NO_DELAY: assert property (
        (ce && st_ff.seq == SEQ_OFF && en_req && st_ff.timing[7:5] == 3'b000)
        ##1 (ce && en_req) |=> st_ff.seq == SEQ_ON)
        else $error("zero delay not honoured");
endmodule // bkr_regs
`default_nettype wire

// File: tb/bkr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module bkr_host_model (
    // link clock
    input wire logic link_clk,
    // request toward the bank
    output logic link_req_valid,
    output bkr_pkg::bkr_req_s link_req,
    // answer from the bank
    input wire logic link_busy,
    input wire logic link_done,
    input wire logic [7:0] link_rdata
);
    import bkr_pkg::*;

    // idle bus at time zero
    initial link_req_valid = 1'b0;
    initial link_req = '0;

    // one byte transfer; ok stays low if no answer comes
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        int n;
        q = 8'h00;
        @(negedge link_clk);
        link_req <= '{wr, a, d};
        link_req_valid <= 1'b1;
        // taken at this edge, busy is low after the last done
        @(posedge link_clk);
        @(negedge link_clk);
        link_req_valid <= 1'b0;
        link_req <= bkr_req_s'(~link_req); // released bus shows no stale value
        for (n = 0; n < 40 && link_done !== 1'b1; n++) @(negedge link_clk);
        ok = (link_done === 1'b1);
        q = link_rdata;
    endtask
endmodule // bkr_host_model
`default_nettype wire

// File: tb/buck_regulator_control_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module buck_regulator_control_regs_test;
    import bkr_pkg::*;
    // clocks, resets and pins
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic link_rst = 1'b1;
    logic [7:0] cond_raw = 8'h00;
    logic enable_pin = 1'b1;
    logic sel_pin = 1'b1;
    // link bus and outputs
    logic link_req_valid;
    bkr_req_s link_req;
    logic link_busy;
    logic link_done;
    logic [7:0] link_rdata;
    logic int_o;
    logic int_oe_n;
    logic pok_o;
    logic pok_oe_n;
    bkr_ctrl_s ctrl;
    int err_total = 0;
    int checks = 0;
    logic [7:0] e;
    logic [7:0] m;
    // reset view: address, value
    logic [15:0] rv [0:16] = '{16'h0000, 16'h0100, 16'h02FF, 16'h035A, 16'h043C, 16'h050A,
        16'h10C0, 16'h11C0, 16'h1210, 16'h1309, 16'h14C3, 16'h16E3, 16'h0600, 16'h1500,
        16'h1700, 16'h2000, 16'hFF00};
    // write view: address, data, readback
    logic [23:0] wv [0:11] = '{24'h020010, 24'h02FFFF, 24'h12FF1F, 24'h13FFFB, 24'h14FFF3,
        24'h15FF00, 24'h01FF00, 24'h165A5A, 24'h121010, 24'h130101, 24'h14C3C3, 24'h16E3E3};

    // clocks, unrelated rates
    always #4 clk = ~clk;
    always #15 link_clk = ~link_clk;

    bkr_regs #(.MS_CYC(10)) u_dut (
        .clk(clk), .rst(rst), .ce(1'b1), .link_clk(link_clk), .link_rst(link_rst),
        .link_req_valid(link_req_valid), .link_req(link_req), .link_busy(link_busy),
        .link_done(link_done), .link_rdata(link_rdata), .cond_raw(cond_raw),
        .enable_pin(enable_pin), .setting_select_pin(sel_pin), .interrupt_out_n_o(int_o),
        .interrupt_out_n_oe_n(int_oe_n), .power_ok_o(pok_o), .power_ok_oe_n(pok_oe_n),
        .ctrl_o(ctrl)
    );
    bkr_host_model u_host (
        .link_clk(link_clk), .link_req_valid(link_req_valid), .link_req(link_req),
        .link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata)
    );

    // byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one transfer; a missing answer is a mismatch
    task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic ok;
        u_host.xfer(w, a, d, q, ok);
        chk({6'h00, ok, link_busy}, 8'h02);
        // later pin changes land on a core falling edge
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xf(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xf(1'b1, a, d, q);
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask
    // wait, bounded, for the output code to reach its target
    task automatic wait_code(input logic [6:0] c);
        for (int n = 0; n < 8000 && ctrl.vout_code !== c; n++) @(negedge clk);
        // registered mode bits settle one edge after the last step
        @(negedge clk);
        chk({1'b0, ctrl.vout_code}, {1'b0, c});
        chk({7'h00, ctrl.ramping}, 8'h00);
    endtask
    task automatic close_out;
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #600000;
        err_total++;
        close_out();
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge link_clk);
        link_rst = 1'b0;
        repeat (3) @(posedge link_clk);
        clks(4);
        // defaults, identity and reserved places
        for (int i = 0; i < 17; i++) rd(rv[i][15:8], rv[i][7:0]);
        // spare bits, read-only and reserved writes
        for (int i = 0; i < 12; i++)
        begin
            wr(wv[i][23:16], wv[i][15:8]);
            rd(wv[i][23:16], wv[i][7:0]);
        end
        // preset choice by pin and gating
        wait_code(7'h40);
        chk({7'h00, ctrl.forced_pwm}, 8'h01);
        wr(8'h11, 8'h85);
        sel_pin = 1'b0;
        // mid-ramp the ramp mode bit rules
        clks(200);
        chk({7'h00, ctrl.ramping}, 8'h01);
        chk({7'h00, ctrl.forced_pwm}, 8'h00);
        wait_code(7'h05);
        chk({7'h00, ctrl.forced_pwm}, 8'h01);
        wr(8'h14, 8'h43);
        clks(20);
        chk({7'h00, ctrl.forced_pwm}, 8'h00);
        wr(8'h14, 8'h42);
        wait_code(7'h40);
        // let the select pin settle before gating returns
        sel_pin = 1'b1;
        clks(200);
        wr(8'h14, 8'hC3);
        // power ok with an 8 ms delay
        cond_raw = 8'h01;
        clks(20);
        wr(8'h12, 8'h05);
        clks(50);
        chk({7'h00, pok_oe_n}, 8'h00);
        clks(50);
        chk({7'h00, pok_oe_n}, 8'h01);
        wr(8'h12, 8'h04);
        clks(10);
        chk({7'h00, pok_oe_n}, 8'h00);
        // zero timeout gives power ok at once
        wr(8'h12, 8'h01);
        clks(4);
        chk({7'h00, pok_oe_n}, 8'h01);
        cond_raw = 8'h00;
        clks(20);
        chk({7'h00, int_oe_n}, 8'h01);
        rd(8'h00, 8'h01);
        // each source: latch, mirror, mask, release
        for (int b = 0; b < 8; b++)
        begin
            m = 8'h01 << b;
            e = m & 8'hEF;
            wr(8'h02, ~m);
            cond_raw = m;
            clks(12);
            chk({7'h00, int_oe_n}, {7'h00, ~|e});
            rd(8'h01, e);
            rd(8'h00, e);
            chk({7'h00, int_oe_n}, 8'h01);
            rd(8'h00, 8'h00);
            wr(8'h02, 8'hFF);
            cond_raw = 8'h00;
            clks(12);
            chk({7'h00, int_oe_n}, 8'h01);
            rd(8'h01, 8'h00);
            rd(8'h00, e);
        end
        // both pins low, then debounce
        enable_pin = 1'b0;
        sel_pin = 1'b0;
        clks(400);
        chk({7'h00, ctrl.low_iq}, 8'h01);
        enable_pin = 1'b1;
        clks(60);
        enable_pin = 1'b0;
        clks(200);
        chk({7'h00, ctrl.on}, 8'h00);
        wr(8'h13, 8'h00);
        enable_pin = 1'b1;
        clks(30);
        chk({7'h00, ctrl.on}, 8'h01);
        enable_pin = 1'b0;
        clks(30);
        wr(8'h14, 8'hD3);
        clks(20);
        chk({7'h00, ctrl.sleep}, 8'h01);
        // drain on while off; open-drain data pins stay low
        wr(8'h12, 8'h10);
        clks(4);
        chk({7'h00, ctrl.drain_on}, 8'h01);
        chk({6'h00, int_o, pok_o}, 8'h00);
        close_out();
    end
endmodule // buck_regulator_control_regs_test
`default_nettype wire
